// ===== core/sensor_frontend_control.sv
// Purpose: Register file and control of regulator, amplifier chain and filter
// Assumes: All inputs synchronous to pclk; converter returns a done pulse
// Notes:   One wait state on every APB access
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

// How it works
// - Two-bit regulator mode: off floating, bypass supply, or regulator on.
// - Upper six regulator control bits unimplemented, read zero.
// - Chain enable bit 7 low powers down amp one, amp two, filter amp.
// - Amp one first-stage gain bits 7..5: 8,16,32,64, then 128 from code four.
// - Amp one offset code bits 4..0, value over 32 of regulated voltage.
// - Amp one second-stage gain is one plus three times code over 32.
// - Chopper bit 7 set supplies 12 kHz chopping clock, else none.
// - Amp two gain bit: zero gives two, one gives one.
// - Amp two offset is regulated voltage times eight-bit code over 256.
// - Filter amp offset code bits 4..0 of enable register, over 32.
// - Bit 5 of amplifier enable register unimplemented, reads zero.
// - Two-bit low-pass cutoff select; high-pass fixed, no field.
// - Filter amp gain equals 56 plus four times six-bit code.
// - Filter clock is prescaled clock divided by divider value plus one.
// - Three-bit prescaler divides system clock by powers of two, 8..1024.
// - Auto-conversion enable forces converter input to filter output.
// - Software-started conversions still accepted in auto-conversion mode.
// - Newest conversion request takes priority over one in progress.
// - Each automatic filter conversion raises the filter interrupt.
// - Low-pass codes map 00..11 to 9, 10, 11, 12 Hz.
// - Ready rising with chain enabled sets filter flag, starts conversion if auto enabled.
// - Prescaler code 000 divides by 8, each code doubles, 111 is 1024.
module sensor_frontend_control
	import sensor_frontend_pkg::*;
#(
	parameter int unsigned CHOP_HALF = sensor_frontend_pkg::CHOP_HALF_CYC
) (
	input  wire logic                                   pclk,
	input  wire logic                                   presetn,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [sensor_frontend_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                            pwdata,
	output logic                                        pready,
	output logic [31:0]                                 prdata,
	output logic                                        pslverr,
	input  wire logic                                   filter_output_ready,
	input  wire logic                                   adc_done,
	output logic [1:0]                                  regulator_mode_sel,
	output logic                                        regulator_on,
	output logic                                        regulator_bypass,
	output logic                                        amp_one_powerdown,
	output logic                                        amp_two_powerdown,
	output logic                                        filter_amp_powerdown,
	output logic [7:0]                                  amp1_stage1_gain,
	output logic [4:0]                                  amp1_offset_sel,
	output logic [6:0]                                  amp1_stage2_gain_num,
	output logic                                        chopper_clk,
	output logic [1:0]                                  amp2_gain,
	output logic [7:0]                                  amp2_offset_sel,
	output logic [4:0]                                  filter_amp_offset_sel,
	output logic [3:0]                                  filter_cutoff_hz,
	output logic [8:0]                                  filter_amp_gain,
	output logic                                        filter_clk_tick,
	output logic                                        adc_channel_override,
	output logic                                        adc_start,
	output logic                                        adc_start_from_filter,
	output logic                                        filter_irq_flag
);

	if (CHOP_HALF < 1 || CHOP_HALF > 65535) begin : g_chk
		$error("CHOP_HALF out of range");
	end

	typedef struct packed {
		logic [1:0]  reg_mode;
		logic [7:0]  amp1_go;
		logic [7:0]  amp1_s2;
		logic [7:0]  amp2_ofs;
		logic [7:0]  amp_en;
		logic [7:0]  filt_ctrl;
		logic        auto_conv;
		logic [2:0]  presc;
		logic [7:0]  div;
		logic        irq;
		logic        busy;
		logic        src_filt;
		logic        rdy_prev;
		logic [9:0]  pre_cnt;
		logic [7:0]  div_cnt;
		logic        tick;
		logic [15:0] chop_cnt;
		logic        chop;
		logic        start;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [1:0]  o_mode;
		logic        o_on;
		logic        o_byp;
		logic        o_pd;
		logic [7:0]  o_g1;
		logic [6:0]  o_g2;
		logic [1:0]  o_amp2g;
		logic [3:0]  o_cut;
		logic [8:0]  o_fg;
		logic        o_ovr;
	} state_t;

	// Decoded outputs match an all-zero register file, so the chain stays powered down in reset
	localparam state_t RST_STATE = '{
		o_pd:    1'b1,
		o_g1:    GAIN1_BASE,
		o_g2:    GAIN2_DEN,
		o_amp2g: 2'h2,
		o_cut:   CUTOFF_BASE_HZ,
		o_fg:    FILT_GAIN_BASE,
		default: '0
	};

	state_t q;
	state_t d;

	logic access;
	logic wr;
	logic sw_start;
	logic rdy_rise;
	logic filt_req;
	logic pre_tick;

	function automatic logic [7:0] stage1_gain(input logic [2:0] code);
		if (code >= GAIN1_SATCODE)
			return GAIN1_MAX;
		return GAIN1_BASE << code;
	endfunction

	function automatic logic [9:0] presc_top(input logic [2:0] code);
		logic [10:0] div_full;
		div_full = PRESC_BASE << code;
		return 10'(div_full - 11'h001);
	endfunction

	// Completing edge of an access: the one where pready is seen high
	assign access   = psel & penable & q.pready;
	assign wr       = access & pwrite;
	assign sw_start = wr && paddr == OFS_CONV && pwdata[POS_SW_START];
	assign rdy_rise = q.amp_en[POS_CHAIN_EN] & filter_output_ready & ~q.rdy_prev;
	assign filt_req = rdy_rise & q.auto_conv;
	// Not an equality: a smaller prescale written mid-count must not wrap the counter
	assign pre_tick = q.pre_cnt >= presc_top(q.presc);

	always_comb begin
		d = q;
		d.pready  = psel & penable & ~q.pready;
		d.pslverr = 1'b0;
		d.start   = 1'b0;
		d.tick    = 1'b0;

		// Read data captured on the same edge that raises pready
		if (psel & penable & ~q.pready) begin
			d.prdata = 32'h0000_0000;
			case (paddr)
				OFS_REGULATOR: d.prdata[1:0] = q.reg_mode;
				OFS_AMP1_GO:   d.prdata[7:0] = q.amp1_go;
				OFS_AMP1_S2:   d.prdata[7:0] = q.amp1_s2;
				OFS_AMP2_OFS:  d.prdata[7:0] = q.amp2_ofs;
				OFS_AMP_EN:    d.prdata[7:0] = q.amp_en;
				OFS_FILT_CTRL: d.prdata[7:0] = q.filt_ctrl;
				OFS_FILT_CLK: begin
					d.prdata[POS_FILT_RDY]                  = q.rdy_prev;
					d.prdata[POS_AUTO_CONV]                 = q.auto_conv;
					d.prdata[POS_PRESC_LO+2:POS_PRESC_LO]   = q.presc;
				end
				OFS_FILT_DIV:  d.prdata[7:0] = q.div;
				OFS_CONV: begin
					d.prdata[POS_IRQ_FLAG] = q.irq;
					d.prdata[POS_BUSY]     = q.busy;
					d.prdata[POS_SRC_FILT] = q.src_filt;
				end
				default:       d.pslverr = 1'b1;
			endcase
		end

		if (wr) begin
			case (paddr)
				OFS_REGULATOR: d.reg_mode = pwdata[1:0];
				OFS_AMP1_GO:   d.amp1_go  = pwdata[7:0];
				// Reserved bits stored as written; software keeps them zero
				OFS_AMP1_S2:   d.amp1_s2  = pwdata[7:0];
				OFS_AMP2_OFS:  d.amp2_ofs = pwdata[7:0];
				OFS_AMP_EN:    d.amp_en   = pwdata[7:0] & 8'hDF;
				OFS_FILT_CTRL: d.filt_ctrl = pwdata[7:0];
				OFS_FILT_CLK: begin
					d.auto_conv = pwdata[POS_AUTO_CONV];
					d.presc     = pwdata[POS_PRESC_LO+2:POS_PRESC_LO];
				end
				OFS_FILT_DIV:  d.div = pwdata[7:0];
				OFS_CONV: begin
					if (pwdata[POS_IRQ_FLAG])
						d.irq = 1'b0;
				end
				default: ;
			endcase
		end

		// Set after the clear so a same-cycle event is never lost
		if (rdy_rise)
			d.irq = 1'b1;

		// Any new request restarts the converter; software wins a tie
		if (sw_start | filt_req) begin
			d.start    = 1'b1;
			d.busy     = 1'b1;
			d.src_filt = ~sw_start;
		end else if (adc_done) begin
			d.busy = 1'b0;
		end

		// Filter clock chain, held idle while the chain is off
		if (!q.amp_en[POS_CHAIN_EN]) begin
			d.pre_cnt  = '0;
			d.div_cnt  = '0;
			d.rdy_prev = 1'b0;
		end else begin
			d.rdy_prev = filter_output_ready;
			if (pre_tick) begin
				d.pre_cnt = '0;
				if (q.div_cnt >= q.div) begin
					d.div_cnt = '0;
					d.tick    = 1'b1;
				end else begin
					d.div_cnt = q.div_cnt + 8'h01;
				end
			end else begin
				d.pre_cnt = q.pre_cnt + 10'h001;
			end
		end

		// Chopping clock, parked low when disabled
		if (q.amp1_s2[POS_CHOP_EN]) begin
			if (q.chop_cnt >= 16'(CHOP_HALF - 1)) begin
				d.chop_cnt = '0;
				d.chop     = ~q.chop;
			end else begin
				d.chop_cnt = q.chop_cnt + 16'h0001;
			end
		end else begin
			d.chop_cnt = '0;
			d.chop     = 1'b0;
		end

		// Decoded analog controls
		d.o_mode  = q.reg_mode;
		d.o_on    = q.reg_mode[1];
		d.o_byp   = q.reg_mode == REG_MODE_BYPASS;
		d.o_pd    = ~q.amp_en[POS_CHAIN_EN];
		d.o_g1    = stage1_gain(q.amp1_go[7:5]);
		d.o_g2    = GAIN2_DEN + 7'(3 * q.amp1_s2[4:0]);
		d.o_amp2g = q.amp_en[POS_AMP2_GAIN] ? 2'h1 : 2'h2;
		d.o_cut   = CUTOFF_BASE_HZ + {2'h0, q.filt_ctrl[7:6]};
		d.o_fg    = FILT_GAIN_BASE + {1'b0, q.filt_ctrl[5:0], 2'h0};
		d.o_ovr   = q.auto_conv;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RST_STATE;
		end else begin
			q <= d;
		end
	end

	assign pready                = q.pready;
	assign prdata                = q.prdata;
	assign pslverr               = q.pslverr;
	assign regulator_mode_sel    = q.o_mode;
	assign regulator_on          = q.o_on;
	assign regulator_bypass      = q.o_byp;
	assign amp_one_powerdown     = q.o_pd;
	assign amp_two_powerdown     = q.o_pd;
	assign filter_amp_powerdown  = q.o_pd;
	assign amp1_stage1_gain      = q.o_g1;
	assign amp1_offset_sel       = q.amp1_go[4:0];
	assign amp1_stage2_gain_num  = q.o_g2;
	assign chopper_clk           = q.chop;
	assign amp2_gain             = q.o_amp2g;
	assign amp2_offset_sel       = q.amp2_ofs;
	assign filter_amp_offset_sel = q.amp_en[4:0];
	assign filter_cutoff_hz      = q.o_cut;
	assign filter_amp_gain       = q.o_fg;
	assign filter_clk_tick       = q.tick;
	assign adc_channel_override  = q.o_ovr;
	assign adc_start             = q.start;
	assign adc_start_from_filter = q.src_filt;
	assign filter_irq_flag       = q.irq;

	// Checks
	AST_REG_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !q.pready && paddr == OFS_REGULATOR) |=> prdata[31:2] == 30'h0)
		else $error("regulator reserved bits not zero");

	AST_AMPEN_BIT5: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !q.pready && paddr == OFS_AMP_EN) |=> !prdata[5])
		else $error("enable bit 5 reads nonzero");

	AST_CHAIN_PD: assert property (@(posedge pclk) disable iff (!presetn)
		!q.amp_en[POS_CHAIN_EN] |=> amp_one_powerdown && amp_two_powerdown && filter_amp_powerdown)
		else $error("chain not powered down");

	AST_GAIN1_SAT: assert property (@(posedge pclk) disable iff (!presetn)
		(q.amp1_go[7:5] >= 3'h4) |=> amp1_stage1_gain == 8'h80)
		else $error("stage one gain not 128");

	AST_CHOP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!q.amp1_s2[POS_CHOP_EN] |=> !chopper_clk)
		else $error("chopper clock runs while disabled");

	AST_AUTO_START: assert property (@(posedge pclk) disable iff (!presetn)
		(filt_req && !sw_start) |=> adc_start && adc_start_from_filter && filter_irq_flag)
		else $error("auto conversion not started");

	AST_NEWEST: assert property (@(posedge pclk) disable iff (!presetn)
		(q.busy && sw_start) |=> adc_start && !adc_start_from_filter && q.busy)
		else $error("newest request not taken");

	AST_OVERRIDE: assert property (@(posedge pclk) disable iff (!presetn)
		q.auto_conv |=> adc_channel_override)
		else $error("channel override missing");

	AST_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!q.amp_en[POS_CHAIN_EN] |-> !filt_req ##1 (!filter_clk_tick && q.pre_cnt == 10'h000))
		else $error("filter logic not idle");

	AST_TICK_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
		filter_clk_tick |=> !filter_clk_tick [*7])
		else $error("filter ticks closer than eight cycles");

	AST_RDY_SETS_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
		rdy_rise |=> filter_irq_flag)
		else $error("ready rise did not set filter flag");

	AST_SW_START: assert property (@(posedge pclk) disable iff (!presetn)
		sw_start |=> adc_start && !adc_start_from_filter)
		else $error("software start not taken");

	AST_BUSY_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		(adc_done && !sw_start && !filt_req) |=> !q.busy)
		else $error("busy not cleared by done");

	AST_AMP2_UNITY: assert property (@(posedge pclk) disable iff (!presetn)
		q.amp_en[POS_AMP2_GAIN] |=> amp2_gain == 2'h1)
		else $error("amp two gain not one");

	AST_AMP2_DOUBLE: assert property (@(posedge pclk) disable iff (!presetn)
		!q.amp_en[POS_AMP2_GAIN] |=> amp2_gain == 2'h2)
		else $error("amp two gain not two");

	AST_CUTOFF_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		(q.filt_ctrl[7:6] == 2'h3) |=> filter_cutoff_hz == 4'hC)
		else $error("top cutoff code not 12 Hz");

	AST_FILT_GAIN_TOP: assert property (@(posedge pclk) disable iff (!presetn)
		(q.filt_ctrl[5:0] == 6'h3F) |=> filter_amp_gain == 9'h134)
		else $error("top filter gain not 308");

	AST_REG_ON: assert property (@(posedge pclk) disable iff (!presetn)
		q.reg_mode[1] |=> regulator_on && !regulator_bypass)
		else $error("regulator not on");

	COV_AUTO: cover property (@(posedge pclk) disable iff (!presetn) filt_req ##1 adc_start);
	COV_RESTART: cover property (@(posedge pclk) disable iff (!presetn) q.busy && sw_start);
	COV_TICK: cover property (@(posedge pclk) disable iff (!presetn) filter_clk_tick);
	COV_CHAIN_OFF_READY: cover property (@(posedge pclk) disable iff (!presetn)
		!q.amp_en[POS_CHAIN_EN] && filter_output_ready);
	COV_IRQ_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_CONV && pwdata[POS_IRQ_FLAG]);

endmodule

// ===== include/sensor_frontend_pkg.sv
// Purpose: Shared constants for the sensor front-end control block
// Assumes: APB with 32-bit data, byte addresses, one aligned word per register
// Notes:   Register fields are 8 bits wide and sit in the low byte
package sensor_frontend_pkg;
	localparam int unsigned SYS_CLK_HZ   = 100_000_000;
	localparam int unsigned CHOP_CLK_HZ  = 12_000;
	localparam int unsigned CHOP_HALF_CYC = SYS_CLK_HZ / (2 * CHOP_CLK_HZ);

	localparam int unsigned ADDR_W = 8;

	// Register byte addresses
	localparam logic [7:0] OFS_REGULATOR   = 8'h00;
	localparam logic [7:0] OFS_AMP1_GO     = 8'h04;
	localparam logic [7:0] OFS_AMP1_S2     = 8'h08;
	localparam logic [7:0] OFS_AMP2_OFS    = 8'h0C;
	localparam logic [7:0] OFS_AMP_EN      = 8'h10;
	localparam logic [7:0] OFS_FILT_CTRL   = 8'h14;
	localparam logic [7:0] OFS_FILT_CLK    = 8'h18;
	localparam logic [7:0] OFS_FILT_DIV    = 8'h1C;
	localparam logic [7:0] OFS_CONV        = 8'h20;

	// Reset values
	localparam logic [7:0] RST_REG8 = 8'h00;

	// Field positions
	localparam int unsigned POS_CHAIN_EN   = 7;
	localparam int unsigned POS_AMP2_GAIN  = 6;
	localparam int unsigned POS_AMP_EN_RSV = 5;
	localparam int unsigned POS_CHOP_EN    = 7;
	localparam int unsigned POS_FILT_RDY   = 6;
	localparam int unsigned POS_AUTO_CONV  = 5;
	localparam int unsigned POS_PRESC_LO   = 2;
	localparam int unsigned POS_SW_START   = 0;
	localparam int unsigned POS_IRQ_FLAG   = 1;
	localparam int unsigned POS_BUSY       = 2;
	localparam int unsigned POS_SRC_FILT   = 3;

	// Regulator mode codes
	localparam logic [1:0] REG_MODE_HIZ    = 2'h0;
	localparam logic [1:0] REG_MODE_BYPASS = 2'h1;

	// Gain, cutoff and prescaler constants
	localparam logic [7:0] GAIN1_BASE   = 8'h08;
	localparam logic [7:0] GAIN1_MAX    = 8'h80;
	localparam logic [2:0] GAIN1_SATCODE = 3'h4;
	localparam logic [6:0] GAIN2_DEN    = 7'h20;
	localparam logic [8:0] FILT_GAIN_BASE = 9'h038;
	localparam logic [3:0] CUTOFF_BASE_HZ = 4'h9;
	localparam logic [10:0] PRESC_BASE  = 11'h008;
endpackage

// ===== tb/sensor_chain_model.sv
// Purpose: Behavioural model of the filter output status and the converter
// Assumes: Ready level is commanded by the bench, start pulses come from the block
// Notes:   Conversion length is an input so one run can answer fast or slow
`timescale 1ns/10ps
module sensor_chain_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        adc_start,
	input  wire logic        ready_cmd,
	input  wire logic [15:0] conv_cycles,
	output logic             filter_output_ready,
	output logic             adc_done
);
	logic [15:0] cnt_q;
	logic        run_q;

	// Status is not gated by power-down so the block's own idling is seen
	assign filter_output_ready = ready_cmd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
			adc_done <= 1'b0;
		end else begin
			adc_done <= 1'b0;
			if (adc_start) begin // Newest start aborts the one in flight
				cnt_q <= conv_cycles;
				run_q <= 1'b1;
			end else if (run_q && cnt_q == 16'h0000) begin
				adc_done <= 1'b1;
				run_q <= 1'b0;
			end else if (run_q) begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end
endmodule

// ===== tb/test_sensor_frontend_control.sv
// Purpose: Self-checking bench for the sensor front-end control block
// Assumes: APB slave answers with its own pready, bench never counts wait states
// Notes:   Chopper half period shortened to 4 cycles to keep the run short
`timescale 1ns/10ps
module test_sensor_frontend_control;
	import sensor_frontend_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ready_cmd, err_v;
	logic        reg_on, reg_byp, pd1, pd2, pdf, chop, tick, ovr, start, src, irq, fo_ready, done;
	logic [1:0]  mode, amp2_g;
	logic [3:0]  cutoff;
	logic [4:0]  ofs1, fofs;
	logic [6:0]  s2num;
	logic [7:0]  paddr, gain1, amp2_ofs;
	logic [8:0]  fgain;
	logic [15:0] conv_cycles;
	logic [31:0] pwdata, prdata, rd_v;
	int          error_cnt, checks_done, start_cnt, i, n;
	// Millisecond settling waits scaled down to keep the run short
	localparam int SETTLE_CYC = 20;

	sensor_frontend_control #(.CHOP_HALF(4)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.filter_output_ready(fo_ready), .adc_done(done), .regulator_mode_sel(mode),
		.regulator_on(reg_on), .regulator_bypass(reg_byp), .amp_one_powerdown(pd1),
		.amp_two_powerdown(pd2), .filter_amp_powerdown(pdf), .amp1_stage1_gain(gain1),
		.amp1_offset_sel(ofs1), .amp1_stage2_gain_num(s2num), .chopper_clk(chop),
		.amp2_gain(amp2_g), .amp2_offset_sel(amp2_ofs), .filter_amp_offset_sel(fofs),
		.filter_cutoff_hz(cutoff), .filter_amp_gain(fgain), .filter_clk_tick(tick),
		.adc_channel_override(ovr), .adc_start(start), .adc_start_from_filter(src),
		.filter_irq_flag(irq));

	sensor_chain_model u_model (
		.pclk(pclk), .presetn(presetn), .adc_start(start), .ready_cmd(ready_cmd),
		.conv_cycles(conv_cycles), .filter_output_ready(fo_ready), .adc_done(done));

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;
	always @(posedge pclk) if (start === 1'b1) start_cnt <= start_cnt + 1;

	task automatic finish_test;
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic time_out;
		error_cnt++;
		finish_test();
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Request held until pready is sampled high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			finish_test();
		end
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Decoded outputs lag the register, so let two edges pass
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk({err_v, rd_v}, {1'b0, exp});
	endtask

	task automatic count_chop(input logic [31:0] exp);
		logic p;
		int   k;
		k = 0;
		p = chop;
		repeat (40) begin
			@(posedge pclk);
			if (chop !== p) k++;
			p = chop;
		end
		chk(k, exp);
	endtask

	// First gap after a reprogram may be partial, so skip two ticks
	task automatic tick_gap(input logic [31:0] exp);
		int k;
		repeat (2) begin
			k = 0;
			while (tick !== 1'b1 && k < 3000) begin
				@(posedge pclk);
				k++;
			end
			if (k >= 3000)
				time_out();
			@(posedge pclk);
		end
		k = 1;
		while (tick !== 1'b1 && k < 3000) begin
			@(posedge pclk);
			k++;
		end
		chk(k, exp);
	endtask

	initial begin
		repeat (100000) @(posedge pclk);
		error_cnt++;
		finish_test();
	end

	initial begin
		{psel, penable, pwrite, presetn, ready_cmd} = 5'b00000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		conv_cycles = 16'h00C8;
		error_cnt = 0;
		checks_done = 0;
		start_cnt = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		for (i = 0; i <= 32; i += 4)
			rd(i[7:0], 32'h0000_0000);
		chk({pd1, pd2, pdf, gain1, amp2_g, s2num}, {3'b111, 8'h08, 2'h2, 7'h20});
		chk({cutoff, fgain}, {4'h9, 9'h038});
		wr(OFS_REGULATOR, 32'h0000_00FF);
		rd(OFS_REGULATOR, 32'h0000_0003);
		for (i = 0; i < 4; i++) begin
			wr(OFS_REGULATOR, i);
			chk({mode, reg_on, reg_byp}, {i[1:0], i[1], i[1:0] == 2'b01});
		end
		repeat (SETTLE_CYC) @(posedge pclk); // Regulator on before amplifier setup
		for (i = 0; i < 8; i++) begin
			wr(OFS_AMP1_GO, {24'h00_0000, i[2:0], 5'h15});
			chk(gain1, (i > 3) ? 8'h80 : (8'h08 << i));
		end
		chk(ofs1, 5'h15);
		rd(OFS_AMP1_GO, 32'h0000_00F5);
		wr(OFS_AMP1_S2, 32'h0000_009F); // Reserved bits kept clear
		chk(s2num, 7'h7D);
		count_chop(10);
		wr(OFS_AMP1_S2, 32'h0000_001F);
		count_chop(0);
		chk(chop, 1'b0);
		wr(OFS_AMP2_OFS, 32'h0000_00A5);
		rd(OFS_AMP2_OFS, 32'h0000_00A5);
		chk(amp2_ofs, 8'hA5);
		wr(OFS_AMP_EN, 32'h0000_00FF);
		rd(OFS_AMP_EN, 32'h0000_00DF);
		chk({pd1, pd2, pdf, amp2_g, fofs}, {3'b000, 2'h1, 5'h1F});
		for (i = 0; i < 4; i++) begin
			wr(OFS_FILT_CTRL, {24'h00_0000, i[1:0], 6'h3F});
			chk({cutoff, fgain}, {4'h9 + i[3:0], 9'h134});
		end
		wr(OFS_FILT_DIV, 32'h0000_0001);
		wr(OFS_FILT_CLK, 32'h0000_0000);
		tick_gap(16);
		wr(OFS_FILT_DIV, 32'h0000_0002);
		wr(OFS_FILT_CLK, 32'h0000_0004);
		tick_gap(48);
		wr(OFS_FILT_DIV, 32'h0000_0000);
		wr(OFS_FILT_CLK, 32'h0000_001C);
		tick_gap(1024);
		wr(OFS_FILT_DIV, 32'h0000_00C7); // 1024 x 200 cycles, near 488 Hz
		rd(OFS_FILT_DIV, 32'h0000_00C7);
		rd(OFS_FILT_CLK, 32'h0000_001C);
		chk(ovr, 1'b0);
		repeat (SETTLE_CYC) @(posedge pclk); // Amplifiers settle before conversions
		wr(OFS_FILT_CLK, 32'h0000_0020);
		chk(ovr, 1'b1);
		ready_cmd <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({start_cnt[3:0], src, irq}, {4'h1, 2'b11});
		rd(OFS_CONV, 32'h0000_004E & 32'h0000_000E);
		wr(OFS_CONV, 32'h0000_0001);
		chk({start_cnt[3:0], src, ovr}, {4'h2, 2'b01});
		rd(OFS_CONV, 32'h0000_0006);
		n = 0;
		while (done !== 1'b1 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400)
			time_out();
		repeat (2) @(posedge pclk);
		rd(OFS_CONV, 32'h0000_0002);
		wr(OFS_CONV, 32'h0000_0002);
		rd(OFS_CONV, 32'h0000_0000);
		ready_cmd <= 1'b0;
		wr(OFS_AMP_EN, 32'h0000_0000);
		ready_cmd <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({start_cnt[3:0], irq, pd1, pd2, pdf}, {4'h2, 4'b0111});
		apb(1'b1, 8'h24, 32'h0000_00FF);
		chk(err_v, 1'b1);
		apb(1'b0, 8'h24, 32'h0000_0000);
		chk({err_v, rd_v}, {1'b1, 32'h0000_0000});
		finish_test();
	end
endmodule
